/* File: eidec_pkg.sv */
package eidec_pkg;

  // ***************************************************************
  // Opcode patterns
  // ***************************************************************
  localparam logic [5:0] XOR_PREFIX = 6'h06;
  localparam logic [7:0] PTR_ADD_PREFIX = 8'hE8;
  localparam logic [7:0] PTR_SUB_PREFIX = 8'hE9;
  localparam logic [7:0] PUSH_PREFIX = 8'hEA;
  localparam logic [7:0] MOVE_PREFIX = 8'hEB;
  localparam logic [3:0] OPERAND_PREFIX = 4'hF;
  localparam logic [15:0] CALL_ACC_WORD = 16'h0014;

  // ***************************************************************
  // Field positions and limits
  // ***************************************************************
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int MOVE_KIND_BIT = 7;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [1:0] RETURN_SEL = 2'h3;
  localparam logic [1:0] THIRD_PTR = 2'h2;
  localparam int PTR_W = 12;
  localparam int PTR_COUNT = 3;
  localparam logic [11:0] PUSH_STEP = 12'h001;

  // ***************************************************************
  // Instruction cycle timing
  // ***************************************************************
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_XOR = 4'h1,
    OP_PTR_ADD = 4'h2,
    OP_PTR_SUB = 4'h3,
    OP_ADD_RET = 4'h4,
    OP_SUB_RET = 4'h5,
    OP_CALL_ACC = 4'h6,
    OP_MOVE_ABS = 4'h7,
    OP_MOVE_IDX = 4'h8,
    OP_PUSH_LIT = 4'h9,
    OP_RESERVED = 4'hA,
    OP_IDLE = 4'hB
  } eidec_op_t;

  // One bit changes on every step away from and back to decode
  typedef enum logic [1:0] {
    ST_DECODE = 2'h0,
    ST_OPERAND = 2'h1,
    ST_IDLE_CYC = 2'h2
  } eidec_state_t;

endpackage : eidec_pkg

/* File: eidec_qgen.sv */
`timescale 1ns/1ps

// ***************************************************************
// Four-phase instruction cycle generator
// ***************************************************************
module eidec_qgen (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  output logic [1:0] q_phase_out,
  output logic cycle_start_out
);

  // Phase counter; cycle_start marks the first phase of each cycle, except the phase 0 that reset loads
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_phase_out <= eidec_pkg::PHASE_RESET;
      cycle_start_out <= 1'b0;
    end else begin
      q_phase_out <= q_phase_out + 2'h1;
      cycle_start_out <= (q_phase_out == eidec_pkg::LAST_PHASE); // Wraps to phase 0 next
    end
  end

endmodule : eidec_qgen

/* File: eidec_decoder.sv */
`timescale 1ns/1ps

module eidec_decoder (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] instr_word_in,
  input wire logic instr_valid_in,
  input wire logic ext_fuse_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] file_data_in,
  input wire logic [35:0] ptr_values_in,
  output logic [1:0] q_phase_out,
  output logic exec_out,
  output logic [3:0] op_out,
  output logic [7:0] alu_result_out,
  output logic flag_n_out,
  output logic flag_z_out,
  output logic flags_we_out,
  output logic acc_we_out,
  output logic file_we_out,
  output logic [7:0] file_addr_out,
  output logic bank_select_use_out,
  output logic indexed_mode_out,
  output logic [1:0] ptr_sel_out,
  output logic ptr_we_out,
  output logic [11:0] ptr_next_out,
  output logic return_pop_out,
  output logic call_push_out,
  output logic push_we_out,
  output logic [7:0] push_data_out,
  output logic move_valid_out,
  output logic [6:0] move_src_off_out,
  output logic [11:0] move_dst_out,
  output logic move_dst_indexed_out
);

  // ***************************************************************
  // Cycle timing
  // ***************************************************************
  logic [1:0] q_phase;
  logic cycle_start;

  eidec_qgen u_qgen (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .q_phase_out(q_phase),
    .cycle_start_out(cycle_start)
  );

  eidec_pkg::eidec_state_t state;
  eidec_pkg::eidec_state_t next_state;
  logic [6:0] src_off;
  logic src_kind;

  // ***************************************************************
  // Pointer unpacking
  // ***************************************************************
  logic [11:0] ptr_arr [0:2];

  // One pointer per slice of the packed bus
  genvar g;
  generate
    for (g = 0; g < eidec_pkg::PTR_COUNT; g = g + 1) begin : g_ptr
      assign ptr_arr[g] = ptr_values_in[g * eidec_pkg::PTR_W +: eidec_pkg::PTR_W];
    end
  endgenerate

  // ***************************************************************
  // Word decode
  // ***************************************************************
  wire [15:0] w = instr_word_in;
  wire ext_on = ext_fuse_in; // Unprogrammed fuse reads high
  wire hit_xor = (w[15:10] == eidec_pkg::XOR_PREFIX);
  wire hit_add = (w[15:8] == eidec_pkg::PTR_ADD_PREFIX);
  wire hit_sub = (w[15:8] == eidec_pkg::PTR_SUB_PREFIX);
  wire hit_push = (w[15:8] == eidec_pkg::PUSH_PREFIX);
  wire hit_move = (w[15:8] == eidec_pkg::MOVE_PREFIX);
  wire hit_call = (w == eidec_pkg::CALL_ACC_WORD);
  wire ret_form = (w[7:6] == eidec_pkg::RETURN_SEL); // Select 3 means third pointer plus return
  wire hit_ext = hit_add | hit_sub | hit_push | hit_move | hit_call;

  // Extended words fall to reserved while the fuse is cleared
  wire eidec_pkg::eidec_op_t dec_op =
      hit_xor ? eidec_pkg::OP_XOR :
      (hit_ext && !ext_on) ? eidec_pkg::OP_RESERVED :
      (hit_add && ret_form) ? eidec_pkg::OP_ADD_RET :
      hit_add ? eidec_pkg::OP_PTR_ADD :
      (hit_sub && ret_form) ? eidec_pkg::OP_SUB_RET :
      hit_sub ? eidec_pkg::OP_PTR_SUB :
      hit_call ? eidec_pkg::OP_CALL_ACC :
      hit_push ? eidec_pkg::OP_PUSH_LIT :
      (hit_move && !w[eidec_pkg::MOVE_KIND_BIT]) ? eidec_pkg::OP_MOVE_ABS :
      hit_move ? eidec_pkg::OP_MOVE_IDX :
      eidec_pkg::OP_NONE;

  wire take = cycle_start & instr_valid_in;
  wire in_decode = (state == eidec_pkg::ST_DECODE);
  wire in_operand = (state == eidec_pkg::ST_OPERAND);
  wire dec = take & in_decode;
  wire opnd = take & in_operand;

  wire is_xor = (dec_op == eidec_pkg::OP_XOR);
  wire is_add = (dec_op == eidec_pkg::OP_PTR_ADD) | (dec_op == eidec_pkg::OP_ADD_RET);
  wire is_sub = (dec_op == eidec_pkg::OP_PTR_SUB) | (dec_op == eidec_pkg::OP_SUB_RET);
  wire is_ret = (dec_op == eidec_pkg::OP_ADD_RET) | (dec_op == eidec_pkg::OP_SUB_RET);
  wire is_push = (dec_op == eidec_pkg::OP_PUSH_LIT);
  wire is_call = (dec_op == eidec_pkg::OP_CALL_ACC);
  wire is_move = (dec_op == eidec_pkg::OP_MOVE_ABS) | (dec_op == eidec_pkg::OP_MOVE_IDX);

  // ***************************************************************
  // Exclusive-OR datapath
  // ***************************************************************
  // Operands must be valid together with the word; result is taken at once
  wire [7:0] xor_res = acc_in ^ file_data_in;
  wire dest_file = w[eidec_pkg::DEST_BIT];
  wire bank_use = w[eidec_pkg::BANK_BIT];
  wire idx_mode = !bank_use && ext_on && (w[7:0] <= eidec_pkg::INDEXED_LIMIT);

  // ***************************************************************
  // Pointer arithmetic
  // ***************************************************************
  // Return forms and push always act on the third pointer
  wire [1:0] sel = (is_ret | is_push) ? eidec_pkg::THIRD_PTR : w[7:6];
  wire [11:0] ptr_cur = ptr_arr[sel];
  wire [11:0] lit6 = {6'h00, w[5:0]}; // Unsigned, zero extended
  wire [11:0] ptr_sum =
      is_push ? ptr_cur - eidec_pkg::PUSH_STEP :
      is_sub ? ptr_cur - lit6 :
      ptr_cur + lit6; // Full pointer width

  // ***************************************************************
  // Second word of a move
  // ***************************************************************
  // A second word without the operand prefix is consumed but moves nothing
  wire opnd_ok = (w[15:12] == eidec_pkg::OPERAND_PREFIX);
  wire [11:0] dst = src_kind ? {5'h00, w[6:0]} : w[11:0];

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      eidec_pkg::ST_DECODE: begin
        if (dec && is_move) begin
          next_state = eidec_pkg::ST_OPERAND;
        end else if (dec && (is_ret || is_call)) begin
          next_state = eidec_pkg::ST_IDLE_CYC;
        end
      end
      eidec_pkg::ST_OPERAND: begin
        if (take) begin
          next_state = eidec_pkg::ST_DECODE;
        end
      end
      eidec_pkg::ST_IDLE_CYC: begin
        if (cycle_start) begin
          next_state = eidec_pkg::ST_DECODE;
        end
      end
      default: begin
        next_state = eidec_pkg::ST_DECODE;
      end
    endcase
  end

  // Operation shown for the cycle that is starting
  wire eidec_pkg::eidec_op_t next_op =
      dec ? dec_op :
      opnd ? (src_kind ? eidec_pkg::OP_MOVE_IDX : eidec_pkg::OP_MOVE_ABS) :
      (state == eidec_pkg::ST_IDLE_CYC) ? eidec_pkg::OP_IDLE :
      eidec_pkg::OP_NONE;

  // State and first-word capture
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= eidec_pkg::ST_DECODE;
      src_off <= 7'h00;
      src_kind <= 1'b0;
    end else begin
      state <= next_state;
      if (dec && is_move) begin
        src_off <= w[6:0];
        src_kind <= w[eidec_pkg::MOVE_KIND_BIT];
      end
    end
  end

  // Controls other than exec_out and q_phase_out change only at a cycle start and stand for the whole cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_phase_out <= eidec_pkg::PHASE_RESET;
      exec_out <= 1'b0;
      op_out <= eidec_pkg::OP_NONE;
      alu_result_out <= 8'h00;
      flag_n_out <= 1'b0;
      flag_z_out <= 1'b0;
      flags_we_out <= 1'b0;
      acc_we_out <= 1'b0;
      file_we_out <= 1'b0;
      file_addr_out <= 8'h00;
      bank_select_use_out <= 1'b0;
      indexed_mode_out <= 1'b0;
      ptr_sel_out <= 2'h0;
      ptr_we_out <= 1'b0;
      ptr_next_out <= 12'h000;
      return_pop_out <= 1'b0;
      call_push_out <= 1'b0;
      push_we_out <= 1'b0;
      push_data_out <= 8'h00;
      move_valid_out <= 1'b0;
      move_src_off_out <= 7'h00;
      move_dst_out <= 12'h000;
      move_dst_indexed_out <= 1'b0;
    end else begin
      q_phase_out <= q_phase;
      exec_out <= cycle_start;
      if (cycle_start) begin
        op_out <= next_op;
        alu_result_out <= xor_res;
        flag_n_out <= xor_res[7];
        flag_z_out <= (xor_res == 8'h00);
        flags_we_out <= dec && is_xor; // Only the xor touches flags
        acc_we_out <= dec && is_xor && !dest_file;
        file_we_out <= dec && is_xor && dest_file;
        file_addr_out <= w[7:0];
        bank_select_use_out <= dec && is_xor && bank_use;
        indexed_mode_out <= dec && is_xor && idx_mode;
        ptr_sel_out <= sel;
        ptr_we_out <= dec && (is_add || is_sub || is_push);
        ptr_next_out <= ptr_sum;
        return_pop_out <= dec && is_ret;
        call_push_out <= dec && is_call;
        push_we_out <= dec && is_push;
        push_data_out <= w[7:0];
        move_valid_out <= opnd && opnd_ok;
        move_src_off_out <= src_off;
        move_dst_out <= dst;
        move_dst_indexed_out <= src_kind;
      end
    end
  end

endmodule : eidec_decoder

/* File: eidec_chk.sv */
`timescale 1ns/1ps

// ***************************************************************
// Decoder port checker
// ***************************************************************
module eidec_chk (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] instr_word_in,
  input wire logic ext_fuse_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] file_data_in,
  input wire logic [35:0] ptr_values_in,
  input wire logic exec_out,
  input wire logic [3:0] op_out,
  input wire logic [7:0] alu_result_out,
  input wire logic flag_n_out,
  input wire logic flag_z_out,
  input wire logic flags_we_out,
  input wire logic acc_we_out,
  input wire logic file_we_out,
  input wire logic bank_select_use_out,
  input wire logic indexed_mode_out,
  input wire logic [1:0] ptr_sel_out,
  input wire logic ptr_we_out,
  input wire logic [11:0] ptr_next_out,
  input wire logic return_pop_out,
  input wire logic call_push_out,
  input wire logic push_we_out,
  input wire logic [7:0] push_data_out
);
  logic [15:0] w_q;
  logic [35:0] p_q;

  // Copy of what the decoder took; a past() of a slice would index with a stale select
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w_q <= 16'h0000;
      p_q <= 36'h0_0000_0000;
    end else begin
      w_q <= instr_word_in;
      p_q <= ptr_values_in;
    end
  end

  // Pointer named by the select field, and an xor in its execute cycle
  wire [11:0] sel_ptr = p_q[12 * w_q[7:6] +: 12];
  wire xor_now = exec_out && op_out == eidec_pkg::OP_XOR;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Idle second cycle of the return forms and the call through accumulator
  sequence idle_cyc;
    exec_out && op_out == eidec_pkg::OP_IDLE && !ptr_we_out && !return_pop_out && !call_push_out;
  endsequence
  // Controls stand three more clocks, then the next cycle starts
  sequence hold_cyc;
    (!exec_out && $stable(op_out)) [*3] ##1 exec_out;
  endsequence

  a_xor_dest_sel: assert property (xor_now |-> acc_we_out == !w_q[9] && file_we_out == w_q[9])
    else $error("xor destination enables wrong");
  a_xor_result_flags: assert property (xor_now |-> alu_result_out == ($past(acc_in) ^ $past(file_data_in))
    && flags_we_out && flag_z_out == (alu_result_out == 8'h00) && flag_n_out == alu_result_out[7])
    else $error("xor result or flags wrong");
  a_xor_bank_mode: assert property (xor_now |-> bank_select_use_out == w_q[8] && indexed_mode_out ==
    (!w_q[8] && $past(ext_fuse_in) && w_q[7:0] <= eidec_pkg::INDEXED_LIMIT))
    else $error("xor bank or indexed mode wrong");
  a_flags_xor_only: assert property (flags_we_out |-> op_out == eidec_pkg::OP_XOR)
    else $error("flags written by non-xor");
  a_ctrl_stand: assert property (exec_out |=> hold_cyc)
    else $error("controls did not stand one instruction cycle");
  a_ptr_add_sum: assert property (exec_out && op_out == eidec_pkg::OP_PTR_ADD |-> ptr_we_out
    && ptr_sel_out == w_q[7:6] && ptr_next_out == sel_ptr + {6'h00, w_q[5:0]})
    else $error("pointer add wrong");
  a_ptr_sub_diff: assert property (exec_out && op_out == eidec_pkg::OP_PTR_SUB |-> ptr_we_out
    && ptr_sel_out == w_q[7:6] && ptr_next_out == sel_ptr - {6'h00, w_q[5:0]})
    else $error("pointer subtract wrong");
  a_ret_then_idle: assert property (exec_out && (op_out == eidec_pkg::OP_ADD_RET || op_out == eidec_pkg::OP_SUB_RET)
    |-> ptr_we_out && return_pop_out && ptr_sel_out == eidec_pkg::THIRD_PTR ##4 idle_cyc)
    else $error("return form wrong");
  a_call_then_idle: assert property (exec_out && op_out == eidec_pkg::OP_CALL_ACC
    |-> call_push_out && !ptr_we_out ##4 idle_cyc)
    else $error("call through accumulator wrong");
  a_push_store: assert property (exec_out && op_out == eidec_pkg::OP_PUSH_LIT |-> push_we_out
    && push_data_out == w_q[7:0] && ptr_sel_out == eidec_pkg::THIRD_PTR && ptr_next_out == p_q[35:24] - 12'h001)
    else $error("literal push wrong");
  a_fuse_off_rsv: assert property (exec_out && !$past(ext_fuse_in) && w_q[15:10] == 6'h3A
    |-> op_out == eidec_pkg::OP_RESERVED && !ptr_we_out && !push_we_out)
    else $error("extended word acted with fuse cleared");
endmodule : eidec_chk

bind eidec_decoder eidec_chk i_eidec_chk (.core_clk_in, .rst_b_in, .instr_word_in, .ext_fuse_in, .acc_in,
  .file_data_in, .ptr_values_in, .exec_out, .op_out, .alu_result_out, .flag_n_out, .flag_z_out, .flags_we_out,
  .acc_we_out, .file_we_out, .bank_select_use_out, .indexed_mode_out, .ptr_sel_out, .ptr_we_out, .ptr_next_out,
  .return_pop_out, .call_push_out, .push_we_out, .push_data_out);

/* File: tb_top.sv */
`timescale 1ns/1ps

// ***************************************************************
// Decoder testbench
// ***************************************************************
module tb_top;
  logic core_clk_in, rst_b_in, instr_valid_in, ext_fuse_in;
  logic [15:0] instr_word_in;
  logic [7:0] acc_in, file_data_in, alu_result_out, file_addr_out, push_data_out;
  logic [35:0] ptr_values_in;
  logic [1:0] q_phase_out, ptr_sel_out;
  logic [3:0] op_out;
  logic exec_out, flag_n_out, flag_z_out, flags_we_out, acc_we_out, file_we_out, bank_select_use_out;
  logic indexed_mode_out, ptr_we_out, return_pop_out, call_push_out, push_we_out, move_valid_out;
  logic move_dst_indexed_out;
  logic [11:0] ptr_next_out, move_dst_out;
  logic [6:0] move_src_off_out;
  logic [15:0] rsv [5] = '{16'hE8A3, 16'hE9C1, 16'hEA7E, 16'hEB05, 16'h0014};
  int num_errors = 0;
  int check_count = 0;

  eidec_decoder i_eidec_decoder (.core_clk_in, .rst_b_in, .instr_word_in, .instr_valid_in, .ext_fuse_in, .acc_in,
    .file_data_in, .ptr_values_in, .q_phase_out, .exec_out, .op_out, .alu_result_out, .flag_n_out, .flag_z_out,
    .flags_we_out, .acc_we_out, .file_we_out, .file_addr_out, .bank_select_use_out, .indexed_mode_out,
    .ptr_sel_out, .ptr_we_out, .ptr_next_out, .return_pop_out, .call_push_out, .push_we_out, .push_data_out,
    .move_valid_out, .move_src_off_out, .move_dst_out, .move_dst_indexed_out);

  // 100 MHz core clock
  initial begin
    core_clk_in = 1'h0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Present a word at a falling edge and wait, bounded, for the cycle that takes it
  task automatic step(input logic [15:0] w);
    int n;
    n = 0;
    instr_word_in = w;
    @(negedge core_clk_in);
    while (exec_out !== 1'h1 && n < 8) begin
      @(negedge core_clk_in);
      n++;
    end
    check(exec_out, 1'h1);
    check(q_phase_out, 2'h0);
  endtask : step

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_xor(input logic [15:0] w, input logic [7:0] a, input logic [7:0] f);
    logic [7:0] r;
    r = a ^ f;
    acc_in = a;
    file_data_in = f;
    step(w);
    check({op_out, alu_result_out, file_addr_out}, {eidec_pkg::OP_XOR, r, w[7:0]});
    check({flags_we_out, flag_n_out, flag_z_out, ptr_we_out}, {1'h1, r[7], r == 8'h00, 1'h0});
    check({acc_we_out, file_we_out}, {!w[9], w[9]});
    check(bank_select_use_out, w[8]);
    check(indexed_mode_out, !w[8] && ext_fuse_in && w[7:0] <= 8'h5F);
  endtask : t_xor

  task automatic t_ptr(input logic [15:0] w, input logic [3:0] op, input logic [1:0] sel, input logic [11:0] nx);
    step(w);
    check(op_out, op);
    check({ptr_we_out, ptr_sel_out, ptr_next_out}, {1'h1, sel, nx});
    check({flags_we_out, return_pop_out}, {1'h0, op >= 4'h4});
  endtask : t_ptr

  // Word in the idle second cycle must be ignored
  task automatic t_idle(input logic [15:0] w);
    step(w);
    check(op_out, eidec_pkg::OP_IDLE);
    check({ptr_we_out, file_we_out, return_pop_out, call_push_out}, 4'h0);
  endtask : t_idle

  task automatic t_move(input logic [15:0] w1, input logic [15:0] w2, input logic [3:0] op, input logic [13:0] exp);
    step(w1);
    check({op_out, move_valid_out}, {op, 1'h0});
    step(w2);
    check({op_out, move_valid_out, move_src_off_out}, {op, exp[13], w1[6:0]});
    if (exp[13]) check({move_dst_indexed_out, move_dst_out}, exp[12:0]);
  endtask : t_move

  // Watchdog sized well above the hundred or so clocks the tests need
  initial begin
    repeat (5000) @(posedge core_clk_in);
    num_errors++;
    stop_test();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    rst_b_in = 1'h0;
    instr_valid_in = 1'h1;
    ext_fuse_in = 1'h1;
    instr_word_in = 16'h0000;
    acc_in = 8'h00;
    file_data_in = 8'h00;
    ptr_values_in = 36'h3_FF0F_0FC0;
    repeat (12) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_b_in = 1'h1;
    t_xor(16'h1A05, 8'hB5, 8'hAF);
    t_xor(16'h1960, 8'h0F, 8'hF0);
    t_xor(16'h1860, 8'h5A, 8'h5A);
    t_xor(16'h185F, 8'h80, 8'h00);
    t_ptr(16'hE8A3, eidec_pkg::OP_PTR_ADD, 2'h2, 12'h422);
    t_ptr(16'hE97F, eidec_pkg::OP_PTR_SUB, 2'h1, 12'h0B1);
    t_ptr(16'hE83F, eidec_pkg::OP_PTR_ADD, 2'h0, 12'hFFF);
    t_ptr(16'hE8E3, eidec_pkg::OP_ADD_RET, 2'h2, 12'h422);
    t_idle(16'hEA01);
    t_ptr(16'hE9C1, eidec_pkg::OP_SUB_RET, 2'h2, 12'h3FE);
    t_idle(16'h1A05);
    step(16'h0014);
    check({op_out, call_push_out, flags_we_out}, {eidec_pkg::OP_CALL_ACC, 2'h2});
    t_idle(16'hE8A3);
    step(16'hEA7E);
    check({op_out, push_we_out, push_data_out}, {eidec_pkg::OP_PUSH_LIT, 1'h1, 8'h7E});
    check({ptr_sel_out, ptr_next_out}, {2'h2, 12'h3FE});
    t_move(16'hEB05, 16'hF123, eidec_pkg::OP_MOVE_ABS, 14'h2123);
    t_move(16'hEB85, 16'hF4AB, eidec_pkg::OP_MOVE_IDX, 14'h302B);
    t_move(16'hEB01, 16'h1A05, eidec_pkg::OP_MOVE_ABS, 14'h0000);
    // Fuse cleared: no indexed xor and every extended word refused
    ext_fuse_in = 1'h0;
    t_xor(16'h1805, 8'h01, 8'h02);
    foreach (rsv[i]) begin
      step(rsv[i]);
      check(op_out, eidec_pkg::OP_RESERVED);
      check({ptr_we_out, push_we_out, call_push_out, return_pop_out}, 4'h0);
    end
    ext_fuse_in = 1'h1;
    instr_valid_in = 1'h0;
    step(16'h1A05);
    check({op_out, file_we_out, flags_we_out}, 6'h00);
    stop_test();
  end
endmodule : tb_top
